// ---- include/shift32_pkg.sv ----
// Shared constants and types for the 32-stage left/right shift register.
package shift32_pkg;

  // Chain length and the positions of the two end stages.
  localparam int STAGE_COUNT = 32;
  localparam int STAGE_FIRST = 0;
  localparam int STAGE_LAST = STAGE_COUNT - 1;

  // Value of every stage and output after reset.
  localparam logic STAGE_RESET = 1'h0;
  localparam logic OUT_RESET = 1'h0;

  // Pin synchroniser length, in flip-flops.
  localparam int SYNC_DEPTH = 2;

  // Position of each pin inside the pin bundle.
  localparam int PIN_CLOCK = 5;
  localparam int PIN_DIR_LEFT = 4;
  localparam int PIN_LOAD_SERIAL = 3;
  localparam int PIN_INHIBIT = 2;
  localparam int PIN_RIGHT_IN = 1;
  localparam int PIN_LEFT_IN = 0;
  localparam int PIN_COUNT = 6;

  // Reset value of the pin bundle and its synchroniser.
  localparam logic [PIN_COUNT-1:0] PINS_RESET = 6'h00;

  // Everything the surrounding logic drives, sampled together as one bundle.
  typedef struct packed {
    logic shiftClk;
    logic dirLeft;
    logic loadSerial;
    logic clockInhibit;
    logic shiftRightIn;
    logic shiftLeftIn;
  } pins_t;

  // Decoded action for one shift clock rising edge.
  typedef enum logic [1:0] {
    ACT_HOLD = 2'b00,
    ACT_RIGHT = 2'b01,
    ACT_LEFT = 2'b10
  } action_t;

endpackage

// ---- rtl/shift_stage.sv ----
// One master-slave storage stage of the shift chain with its direction mux.
`timescale 1ns/1ps

module shift_stage
  import shift32_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic fromLeft,
  input wire logic fromRight,
  input wire logic shiftRight,
  input wire logic shiftLeft,
  output logic q
);

  logic stage_q;
  logic stage_d;
  wire logic nextBit = shiftRight ? fromLeft : fromRight;

  // R1 static stage store
  // The stage keeps its content on every cycle with no shift request.
  assign stage_d = (shiftRight || shiftLeft) ? nextBit : stage_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage_q <= STAGE_RESET;
    end else begin
      stage_q <= stage_d;
    end
  end

  assign q = stage_q;

endmodule

// ---- rtl/shift_reg_32_left_right.sv ----
// Top of the 32-stage left/right static shift register with recirculation.
//
// Contract
// R1 - Thirty-two static stages hold data while idle.
// R2 - Direction low, serial: right input enters stage 1.
// R3 - Direction high, serial: left input enters stage 32.
// R4 - End stages reach outputs on next falling edge.
// R5 - Clock inhibit high blocks every shift.
// R6 - Recirculate right: stage 32 feeds stage 1.
// R7 - Recirculate left: stage 1 feeds stage 32.
// R8 - Left output shows stage 1, right shows 32.
// R9 - Driver keeps controls stable around rising edges.
`timescale 1ns/1ps

module shift_reg_32_left_right
  import shift32_pkg::*;
#(
  parameter int STAGES = STAGE_COUNT
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic shiftClk,
  input wire logic dirLeft,
  input wire logic loadSerial,
  input wire logic clockInhibit,
  input wire logic shiftRightIn,
  input wire logic shiftLeftIn,
  output logic shiftLeftOut,
  output logic shiftRightOut
);

  localparam int LAST = STAGES - 1;

  // Two-flop synchroniser for all pins. The first rank is read only by the second.
  pins_t pinsRaw;
  logic [PIN_COUNT-1:0] meta_q;
  logic [PIN_COUNT-1:0] sync_q;
  pins_t pins;

  assign pinsRaw = '{
    shiftClk: shiftClk,
    dirLeft: dirLeft,
    loadSerial: loadSerial,
    clockInhibit: clockInhibit,
    shiftRightIn: shiftRightIn,
    shiftLeftIn: shiftLeftIn
  };

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= PINS_RESET;
      sync_q <= PINS_RESET;
    end else begin
      meta_q <= pinsRaw;
      sync_q <= meta_q;
    end
  end

  assign pins = pins_t'(sync_q);

  // Previous synchronised shift clock level, for edge detection.
  logic clkPrev_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clkPrev_q <= 1'h0;
    end else begin
      clkPrev_q <= pins.shiftClk;
    end
  end

  wire logic riseEdge = pins.shiftClk && !clkPrev_q;
  wire logic fallEdge = !pins.shiftClk && clkPrev_q;

  // Controls are sampled with the same synchroniser delay as the clock pin, so
  // a driver that holds them steady around the edge is seen consistently.
  // R9 controls sampled at edge
  // R5 inhibit blocks shift
  action_t action;
  assign action = (!riseEdge || pins.clockInhibit) ? ACT_HOLD :
                  (pins.dirLeft ? ACT_LEFT : ACT_RIGHT);

  wire logic shiftRight = (action == ACT_RIGHT);
  wire logic shiftLeft = (action == ACT_LEFT);

  // Stage contents, index 0 is stage 1 and index LAST is stage 32.
  logic [STAGES-1:0] stageQ;

  // R2 serial right entry
  // R6 recirculate right entry
  wire logic rightEntry = pins.loadSerial ? pins.shiftRightIn : stageQ[LAST];
  // R3 serial left entry
  // R7 recirculate left entry
  wire logic leftEntry = pins.loadSerial ? pins.shiftLeftIn : stageQ[0];

  // R1 chain of storage stages
  genvar i;
  generate
    for (i = 0; i < STAGES; i++) begin : gStage
      wire logic fromLeft = (i == 0) ? rightEntry : stageQ[(i == 0) ? 0 : i - 1];
      wire logic fromRight = (i == LAST) ? leftEntry : stageQ[(i == LAST) ? LAST : i + 1];
      shift_stage uStage (
        .clk(clk),
        .rst(rst),
        .fromLeft(fromLeft),
        .fromRight(fromRight),
        .shiftRight(shiftRight),
        .shiftLeft(shiftLeft),
        .q(stageQ[i])
      );
    end
  endgenerate

  // The end stages are copied out only on a falling edge, so a value loaded on a
  // rising edge is not visible until the clock returns low, which lets a
  // cascaded register with a slow clock edge capture the old bit safely.
  logic leftOut_q;
  logic leftOut_d;
  logic rightOut_q;
  logic rightOut_d;

  // R4 outputs on falling edge
  // R8 end stages to outputs
  assign leftOut_d = fallEdge ? stageQ[0] : leftOut_q;
  assign rightOut_d = fallEdge ? stageQ[LAST] : rightOut_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      leftOut_q <= OUT_RESET;
      rightOut_q <= OUT_RESET;
    end else begin
      leftOut_q <= leftOut_d;
      rightOut_q <= rightOut_d;
    end
  end

  assign shiftLeftOut = leftOut_q;
  assign shiftRightOut = rightOut_q;

  // Checks on the chain and the outputs.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence rightSerial_s;
    riseEdge && !pins.clockInhibit && !pins.dirLeft && pins.loadSerial;
  endsequence

  sequence leftSerial_s;
    riseEdge && !pins.clockInhibit && pins.dirLeft && pins.loadSerial;
  endsequence

  property chainStatic_p;
    !riseEdge |=> $stable(stageQ);
  endproperty

  idle_chain_hold_a: assert property (chainStatic_p) // R1
    else $error("Stage contents changed without a shift clock rising edge.");

  right_serial_load_a: assert property ( // R2
    rightSerial_s |=> stageQ[0] == $past(pins.shiftRightIn)
      && stageQ[LAST:1] == $past(stageQ[LAST-1:0]))
    else $error("Right shift did not load the right serial input.");

  left_serial_load_a: assert property ( // R3
    leftSerial_s |=> stageQ[LAST] == $past(pins.shiftLeftIn)
      && stageQ[LAST-1:0] == $past(stageQ[LAST:1]))
    else $error("Left shift did not load the left serial input.");

  out_late_update_a: assert property ( // R4
    !fallEdge |=> $stable(shiftLeftOut) && $stable(shiftRightOut))
    else $error("Serial outputs changed away from a falling edge.");

  inhibit_no_shift_a: assert property ( // R5
    riseEdge && pins.clockInhibit |=> stageQ == $past(stageQ))
    else $error("Chain shifted while clock inhibit was high.");

  right_recirculate_a: assert property ( // R6
    riseEdge && !pins.clockInhibit && !pins.dirLeft && !pins.loadSerial
      |=> stageQ == {$past(stageQ[LAST-1:0]), $past(stageQ[LAST])})
    else $error("Right recirculation did not move stage 32 into stage 1.");

  left_recirculate_a: assert property ( // R7
    riseEdge && !pins.clockInhibit && pins.dirLeft && !pins.loadSerial
      |=> stageQ == {$past(stageQ[0]), $past(stageQ[LAST:1])})
    else $error("Left recirculation did not move stage 1 into stage 32.");

  out_end_stage_a: assert property ( // R8
    fallEdge |=> shiftLeftOut == $past(stageQ[0])
      && shiftRightOut == $past(stageQ[LAST]))
    else $error("Serial outputs do not show the end stages after a falling edge.");

  // The loaded bit itself must reach the left output one cycle after the fall is seen.
  serial_to_output_a: assert property ( // R4
    rightSerial_s ##1 (!fallEdge) [*3] ##1 fallEdge
      |=> shiftLeftOut == $past(pins.shiftRightIn, 5))
    else $error("Loaded bit did not reach the left output at the falling edge.");

  right_serial_c: cover property (rightSerial_s ##[1:40] fallEdge);
  left_serial_c: cover property (leftSerial_s ##[1:40] fallEdge);
  inhibit_rise_c: cover property (riseEdge && pins.clockInhibit);
  recirculate_c: cover property (riseEdge && !pins.clockInhibit && !pins.loadSerial);

endmodule

// ---- dv/pin_driver.sv ----
// Model of the surrounding logic that drives the shift register pins.
`timescale 1ns/1ps

module pin_driver (
  input wire logic clk,
  output logic shiftClk,
  output logic dirLeft,
  output logic loadSerial,
  output logic clockInhibit,
  output logic shiftRightIn,
  output logic shiftLeftIn
);
  initial begin
    shiftClk = 1'h0;
    dirLeft = 1'h0;
    loadSerial = 1'h1;
    clockInhibit = 1'h0;
    shiftRightIn = 1'h0;
    shiftLeftIn = 1'h0;
  end

  // stable controls
  // Controls settle four clocks ahead of the rise and stay put while the clock is high.
  task automatic rise(input logic d, input logic l, input logic c, input logic r,
                      input logic lf);
    @(negedge clk);
    dirLeft = d;
    loadSerial = l;
    clockInhibit = c;
    shiftRightIn = r;
    shiftLeftIn = lf;
    repeat (4) @(negedge clk);
    shiftClk = 1'h1;
    repeat (4) @(negedge clk);
  endtask

  // Serial data is no longer held after the fall, so it flips to expose stale sampling.
  task automatic fall();
    shiftClk = 1'h0;
    repeat (4) @(negedge clk);
    shiftRightIn = ~shiftRightIn;
    shiftLeftIn = ~shiftLeftIn;
  endtask
endmodule

// ---- dv/test_shift_reg_32_left_right.sv ----
// Self-checking bench for the 32-stage left/right shift register.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("Error at %0t: got %b want %b", $time, a, b); end end

module test_shift_reg_32_left_right;
  import shift32_pkg::*;
  logic clk, rst, shiftClk, dirLeft, loadSerial, clockInhibit, shiftRightIn, shiftLeftIn;
  logic shiftLeftOut, shiftRightOut;
  int error_cnt = 0;
  int n_checks = 0;
  int st[$];
  int unsigned seed = 59;
  int unsigned r;

  shift_reg_32_left_right #(.STAGES(STAGE_COUNT)) dut (.clk(clk), .rst(rst),
    .shiftClk(shiftClk), .dirLeft(dirLeft), .loadSerial(loadSerial),
    .clockInhibit(clockInhibit), .shiftRightIn(shiftRightIn), .shiftLeftIn(shiftLeftIn),
    .shiftLeftOut(shiftLeftOut), .shiftRightOut(shiftRightOut));

  pin_driver drv (.clk(clk), .shiftClk(shiftClk), .dirLeft(dirLeft),
    .loadSerial(loadSerial), .clockInhibit(clockInhibit), .shiftRightIn(shiftRightIn),
    .shiftLeftIn(shiftLeftIn));

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One full clock pulse; outputs must not move until the falling edge.
  task automatic step(input logic d, input logic l, input logic c, input logic ri,
                      input logic li);
    logic oldL, oldR;
    int nb;
    oldL = shiftLeftOut;
    oldR = shiftRightOut;
    drv.rise(d, l, c, ri, li);
    `CHK(shiftLeftOut, oldL)
    `CHK(shiftRightOut, oldR)
    if (!c) begin
      if (!d) begin
        nb = l ? int'(ri) : st[31];
        st.push_front(nb);
        void'(st.pop_back());
      end else begin
        nb = l ? int'(li) : st[0];
        st.push_back(nb);
        void'(st.pop_front());
      end
    end
    drv.fall();
    repeat (2) @(negedge clk);
    `CHK(shiftLeftOut, 1'(st[0]))
    `CHK(shiftRightOut, 1'(st[31]))
  endtask

  initial begin
    rst = 1'h1;
    for (int k = 0; k < STAGE_COUNT; k++) begin
      st.push_back(0);
    end
    repeat (3) @(negedge clk);
    rst = 1'h0;
    repeat (2) @(negedge clk);
    `CHK(shiftLeftOut, OUT_RESET)
    `CHK(shiftRightOut, OUT_RESET)
    for (int k = 0; k < 36; k++) begin
      r = xs();
      step(1'h0, 1'h1, 1'h0, r[0], r[1]);
    end
    for (int k = 0; k < 36; k++) begin
      r = xs();
      step(1'h1, 1'h1, 1'h0, r[0], r[1]);
    end
    for (int k = 0; k < 8; k++) begin
      r = xs();
      step(r[0], r[1], 1'h1, r[2], r[3]);
    end
    // Idle a long stretch with the shift clock low; contents must persist.
    repeat (200) @(negedge clk);
    for (int k = 0; k < 34; k++) begin
      step(1'h0, 1'h0, 1'h0, 1'h1, 1'h1);
    end
    for (int k = 0; k < 34; k++) begin
      step(1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    end
    for (int k = 0; k < 160; k++) begin
      r = xs();
      step(r[0], r[1], r[4:2] == 3'h0, r[5], r[6]);
    end
    end_sim();
  end
endmodule
